// File: pkg/sbbe_defs.vh
`ifndef SBBE_DEFS_VH
`define SBBE_DEFS_VH
// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define SBBE_ADDR_MODE     12'h0EB
`define SBBE_ADDR_CTRL     12'h0EC
`define SBBE_ADDR_DATA     12'h0CC
`define SBBE_ADDR_PORT     12'h0C2
// ----------------------------------------------------------------
// control/status field positions
// ----------------------------------------------------------------
`define SBBE_BIT_DIR       3
`define SBBE_BIT_VERIFY    2
`define SBBE_BIT_NOACK     1
`define SBBE_BIT_BUSY      0
// ----------------------------------------------------------------
// mode control field positions
// ----------------------------------------------------------------
`define SBBE_BIT_PSEL      0
`define SBBE_BIT_HWEN      1
`define SBBE_BIT_STOP      2
`define SBBE_BIT_START     3
// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SBBE_RST_CTRL      8'h00
`define SBBE_RST_MODE      8'h00
`define SBBE_RST_PORT      8'hFF
// ----------------------------------------------------------------
// timing: bus clock in Hz and system clock in Hz
// ----------------------------------------------------------------
`define SBBE_BUS_HZ        62500
`define SBBE_SYS_HZ        25000000
`define SBBE_QTR_CYC       ((`SBBE_SYS_HZ / `SBBE_BUS_HZ) / 4)
`define SBBE_GLITCH_LEN    3
`endif

// File: rtl/sbbe_deglitch.v
`include "sbbe_defs.vh"
// ----------------------------------------------------------------
// two-stage synchroniser plus counter-based stable filter
// ----------------------------------------------------------------
module sbbe_deglitch #(
    parameter LEN = `SBBE_GLITCH_LEN
) (
    input  wire pclk,
    input  wire presetn,
    input  wire din,
    output reg  dout
);
    reg       sync_a;
    reg       sync_b;
    reg [3:0] cnt;

    // synchronise, then accept a level only after LEN+1 stable cycles
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync_a <= 1'b1;
            sync_b <= 1'b1;
            cnt    <= 4'h0;
            dout   <= 1'b1;
        end
        else
        begin
            sync_a <= din;
            sync_b <= sync_a;
            if (sync_b == dout)
                cnt <= 4'h0;
            else if (cnt == LEN[3:0])
            begin
                cnt  <= 4'h0;
                dout <= sync_b;
            end
            else
                cnt <= cnt + 4'h1;
        end
    end
endmodule // sbbe_deglitch

// File: rtl/sbbe_tick.v
`include "sbbe_defs.vh"
// ----------------------------------------------------------------
// quarter-bit tick generator for the serial clock
// ----------------------------------------------------------------
module sbbe_tick #(
    parameter QTR = `SBBE_QTR_CYC
) (
    input  wire pclk,
    input  wire presetn,
    input  wire run,
    output reg  tick
);
    reg [7:0] cnt;

    // counts while a byte runs, pulses once per quarter bit
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt  <= 8'h00;
            tick <= 1'b0;
        end
        else if (!run)
        begin
            cnt  <= 8'h00;
            tick <= 1'b0;
        end
        else if (cnt == QTR[7:0] - 8'h01)
        begin
            cnt  <= 8'h00;
            tick <= 1'b1;
        end
        else
        begin
            cnt  <= cnt + 8'h01;
            tick <= 1'b0;
        end
    end
endmodule // sbbe_tick

// File: rtl/sbbe_engine.v
// Decided for this implementation: the APB slave port.
`include "sbbe_defs.vh"
// Overview of operation
// - direction bit: set transmit, clear receive
// - verify set whenever busy set
// - verify clears on driven/sampled data mismatch
// - verify write sets vsync interrupt enable
// - no-ack flag raised, cleared on busy
// - writing busy starts one byte when a mode bit is set
// - busy self-clears; software cannot clear
// - data register blocked while busy
// - reset clears busy and mode bits
// - serial outputs ANDed with port outputs
// - three-wire mode uses pins zero, one, three
// - I2C mode uses pins zero, one
// - shift mode uses pins zero, one
// - verify only when transmitting hardware bus
// - incoming clock and data are deglitched
// - no acknowledge after final received byte
// - pins are open drain, pull low only
// - bus clock fixed at 62.5 kHz
// - two mode bits choose the function
// - start condition before byte when enabled
// - stop condition after byte when enabled
module sbbe_engine (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output reg  [31:0] prdata,
    output wire        pslverr,
    input  wire        port_c_pin_zero_in,
    input  wire        port_c_pin_one_in,
    output wire        port_c_pin_zero_out,
    output wire        port_c_pin_zero_oe,
    output wire        port_c_pin_one_out,
    output wire        port_c_pin_one_oe,
    output wire        port_c_pin_three_out,
    output wire        port_c_pin_three_oe,
    output reg         vsync_irq_enable
);
    // ----------------------------------------------------------------
    // states
    // ----------------------------------------------------------------
    localparam ST_IDLE  = 5'b00001;
    localparam ST_START = 5'b00010;
    localparam ST_BIT   = 5'b00100;
    localparam ST_STOP  = 5'b01000;
    localparam ST_DONE  = 5'b10000;

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    reg  [3:0] serial_mode_control;
    reg  [7:0] port_c_data;
    reg  [7:0] shift_data_reg;
    reg        direction_bit;
    reg        verify_flag;
    reg        no_ack_flag;
    reg        transfer_busy;
    reg  [4:0] state;
    reg  [3:0] bit_idx;
    reg  [1:0] phase;
    reg        drv_scl;
    reg        drv_sda;
    reg        drv_sen;
    reg        latch_stop;
    wire       scl_in;
    wire       sda_in;
    wire       tick;
    wire       hw_bus_enable;
    wire       proto_sel;
    wire       start_enable;
    wire       stop_enable;
    wire       mode_on;
    wire       sbus_mode;
    wire       shift_mode;
    wire       wr;
    wire       rd;
    wire       last_bit;
    wire       ack_slot;

    assign hw_bus_enable = serial_mode_control[`SBBE_BIT_HWEN];
    assign proto_sel     = serial_mode_control[`SBBE_BIT_PSEL];
    assign start_enable  = serial_mode_control[`SBBE_BIT_START];
    assign stop_enable   = serial_mode_control[`SBBE_BIT_STOP];
    // mode decode from the two mode bits
    assign mode_on    = hw_bus_enable | proto_sel;
    assign sbus_mode  = hw_bus_enable & proto_sel;
    assign shift_mode = ~hw_bus_enable & proto_sel;
    assign last_bit   = hw_bus_enable ? (bit_idx == 4'h8) : (bit_idx == 4'h7);
    assign ack_slot   = hw_bus_enable && (bit_idx == 4'h8);

    // APB handshakes: zero wait states
    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign wr = psel & penable & pwrite;
    assign rd = psel & penable & ~pwrite;

    // ----------------------------------------------------------------
    // input filtering
    // ----------------------------------------------------------------
    sbbe_deglitch #(.LEN(`SBBE_GLITCH_LEN)) u_scl_filt (
        .pclk    (pclk),
        .presetn (presetn),
        .din     (port_c_pin_zero_in),
        .dout    (scl_in)
    );
    sbbe_deglitch #(.LEN(`SBBE_GLITCH_LEN)) u_sda_filt (
        .pclk    (pclk),
        .presetn (presetn),
        .din     (port_c_pin_one_in),
        .dout    (sda_in)
    );
    sbbe_tick #(.QTR(`SBBE_QTR_CYC)) u_tick (
        .pclk    (pclk),
        .presetn (presetn),
        .run     (transfer_busy),
        .tick    (tick)
    );

    // ----------------------------------------------------------------
    // read mux
    // ----------------------------------------------------------------
    always @*
    begin
        prdata = 32'h0000_0000;
        case (paddr)
            `SBBE_ADDR_CTRL:
            begin
                prdata[`SBBE_BIT_VERIFY] = verify_flag;
                prdata[`SBBE_BIT_NOACK]  = no_ack_flag;
                prdata[`SBBE_BIT_BUSY]   = transfer_busy;
            end
            `SBBE_ADDR_DATA:
                if (!transfer_busy)
                    prdata[7:0] = shift_data_reg;
            `SBBE_ADDR_PORT:
                prdata[7:0] = port_c_data;
            default:
                prdata = 32'h0000_0000;
        endcase
    end

    // ----------------------------------------------------------------
    // configuration registers written by software
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            serial_mode_control <= 4'h0;
            port_c_data         <= `SBBE_RST_PORT;
            direction_bit       <= 1'b0;
            vsync_irq_enable    <= 1'b0;
        end
        else if (wr)
        begin
            if (paddr == `SBBE_ADDR_MODE && !transfer_busy)
                serial_mode_control <= pwdata[3:0];
            if (paddr == `SBBE_ADDR_PORT)
                port_c_data <= pwdata[7:0];
            if (paddr == `SBBE_ADDR_CTRL)
            begin
                direction_bit    <= pwdata[`SBBE_BIT_DIR];
                vsync_irq_enable <= pwdata[`SBBE_BIT_VERIFY];
            end
        end
    end

    // ----------------------------------------------------------------
    // byte engine: busy, flags, shift register, line drive
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            transfer_busy  <= 1'b0;
            verify_flag    <= 1'b0;
            no_ack_flag    <= 1'b0;
            shift_data_reg <= 8'h00;
            state          <= ST_IDLE;
            bit_idx        <= 4'h0;
            phase          <= 2'b00;
            drv_scl        <= 1'b1;
            drv_sda        <= 1'b1;
            drv_sen        <= 1'b1;
            latch_stop     <= 1'b0;
        end
        else
        begin
            case (state)
                ST_IDLE:
                begin
                    drv_scl <= 1'b1;
                    drv_sda <= 1'b1;
                    if (wr && paddr == `SBBE_ADDR_DATA)
                        shift_data_reg <= pwdata[7:0];
                    if (wr && paddr == `SBBE_ADDR_CTRL && pwdata[`SBBE_BIT_BUSY] && mode_on)
                    begin
                        transfer_busy <= 1'b1;
                        no_ack_flag   <= 1'b0;
                        verify_flag   <= 1'b1;
                        latch_stop    <= stop_enable & hw_bus_enable;
                        bit_idx       <= 4'h0;
                        phase         <= 2'b00;
                        state <= (start_enable && hw_bus_enable) ? ST_START : ST_BIT;
                    end
                end
                ST_START:
                    if (tick)
                    begin
                        // data falls while clock high, then clock falls
                        phase <= phase + 2'b01;
                        case (phase)
                            2'b00: drv_sda <= 1'b0;
                            2'b01: drv_sen <= ~sbus_mode;
                            2'b10: drv_scl <= 1'b0;
                            default: state <= ST_BIT;
                        endcase
                    end
                ST_BIT:
                    if (tick)
                    begin
                        phase <= phase + 2'b01;
                        case (phase)
                            2'b00:
                            begin
                                drv_scl <= 1'b0;
                                if (ack_slot)
                                    drv_sda <= direction_bit | latch_stop;
                                else
                                    drv_sda <= direction_bit ? shift_data_reg[7] : 1'b1;
                            end
                            2'b01: drv_scl <= 1'b1;
                            2'b10:
                            begin
                                if (ack_slot)
                                begin
                                    if (direction_bit && sda_in)
                                        no_ack_flag <= 1'b1;
                                end
                                else
                                begin
                                    shift_data_reg <= {shift_data_reg[6:0], sda_in};
                                    if (direction_bit && hw_bus_enable && scl_in && sda_in != drv_sda)
                                        verify_flag <= 1'b0;
                                end
                            end
                            default:
                            begin
                                drv_scl <= 1'b0;
                                bit_idx <= bit_idx + 4'h1;
                                if (last_bit)
                                    state <= latch_stop ? ST_STOP : ST_DONE;
                            end
                        endcase
                    end
                ST_STOP:
                    if (tick)
                    begin
                        // data low, clock high, then data rises
                        phase <= phase + 2'b01;
                        case (phase)
                            2'b00: drv_sda <= 1'b0;
                            2'b01: drv_scl <= 1'b1;
                            2'b10: drv_sda <= 1'b1;
                            default:
                            begin
                                drv_sen <= 1'b1;
                                state   <= ST_DONE;
                            end
                        endcase
                    end
                ST_DONE:
                begin
                    drv_sda       <= latch_stop ? 1'b1 : drv_sda;
                    transfer_busy <= 1'b0;
                    state         <= ST_IDLE;
                end
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // pin combination: open drain, ANDed with port outputs
    // ----------------------------------------------------------------
    assign port_c_pin_zero_out  = 1'b0;
    assign port_c_pin_one_out   = 1'b0;
    assign port_c_pin_three_out = 1'b0;
    assign port_c_pin_zero_oe   = ~(port_c_data[0] & (~mode_on | drv_scl));
    assign port_c_pin_one_oe    = ~(port_c_data[1] & (~mode_on | drv_sda));
    assign port_c_pin_three_oe  = ~(port_c_data[3] & (~sbus_mode | drv_sen));
endmodule // sbbe_engine

// File: tb/sbbe_engine_props.sv
`include "sbbe_defs.vh"
module sbbe_engine_props (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        port_c_pin_zero_in,
    input wire logic        port_c_pin_one_in,
    input wire logic        port_c_pin_zero_out,
    input wire logic        port_c_pin_zero_oe,
    input wire logic        port_c_pin_one_out,
    input wire logic        port_c_pin_one_oe,
    input wire logic        port_c_pin_three_out,
    input wire logic        port_c_pin_three_oe,
    input wire logic        vsync_irq_enable
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------------------------------
    // shadow of mode, port data and the last byte start
    // ----------------------------------------------------------------
    logic [3:0]  mode_q;
    logic [7:0]  port_q;
    logic        go_dir, go_hw, go_start;
    logic [15:0] since_go, hi_cnt;
    wire         wr = psel && penable && pready && pwrite;
    wire         rd = psel && penable && pready && !pwrite;

    // track writes seen at the access edge; count cycles since a start
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode_q   <= 4'h0;
            port_q   <= 8'hFF;
            since_go <= 16'hFFFF;
            {go_dir, go_hw, go_start} <= 3'h0;
            hi_cnt   <= 16'h0000;
        end
        else
        begin
            hi_cnt <= port_c_pin_zero_oe ? 16'h0000 : hi_cnt + {15'h0000, hi_cnt != 16'hFFFF};
            if (since_go != 16'hFFFF)
                since_go <= since_go + 16'h0001;
            if (wr && paddr == `SBBE_ADDR_MODE)
                mode_q <= pwdata[3:0];
            if (wr && paddr == `SBBE_ADDR_PORT)
                port_q <= pwdata[7:0];
            if (wr && paddr == `SBBE_ADDR_CTRL && pwdata[`SBBE_BIT_BUSY] && mode_q[1:0] != 2'h0)
            begin
                since_go <= 16'h0000;
                go_dir   <= pwdata[`SBBE_BIT_DIR];
                go_hw    <= mode_q[1];
                go_start <= mode_q[3] & mode_q[1];
            end
        end
    end

    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_early_ctrl;
        rd && paddr == `SBBE_ADDR_CTRL && since_go < 16'h012C;
    endsequence
    sequence s_start_win;
        ##[0:400] port_c_pin_one_oe;
    endsequence

    a_pins_open_drain: assert property (!port_c_pin_zero_out && !port_c_pin_one_out && !port_c_pin_three_out)
        else $error("pin output driven high");
    a_port_and_gate: assert property ((port_c_pin_zero_oe || port_q[0]) && (port_c_pin_one_oe || port_q[1])
        && (port_c_pin_three_oe || port_q[3])) else $error("port low bit not reaching pin");
    a_pin_three_free: assert property (mode_q[1:0] != 2'h3 |-> port_c_pin_three_oe == !port_q[3])
        else $error("pin three driven outside three wire mode");
    a_busy_on_go: assert property (s_early_ctrl |-> prdata[`SBBE_BIT_BUSY])
        else $error("busy not set after start");
    a_verify_on_go: assert property (s_early_ctrl ##0 (go_dir && go_hw) |-> prdata[`SBBE_BIT_VERIFY])
        else $error("verify not set at start of transmit");
    a_noack_cleared: assert property (s_early_ctrl ##0 go_hw |-> !prdata[`SBBE_BIT_NOACK])
        else $error("no ack flag not cleared by start");
    a_data_locked: assert property (rd && paddr == `SBBE_ADDR_DATA && since_go < 16'h012C |-> prdata == 32'h0)
        else $error("data register readable while busy");
    a_busy_ends: assert property (rd && paddr == `SBBE_ADDR_CTRL && since_go > 16'h1388 |-> !prdata[0])
        else $error("busy never cleared");
    a_start_first: assert property (since_go == 16'h0001 && go_start |-> !port_c_pin_zero_oe throughout s_start_win)
        else $error("no start condition before clocking");
    a_scl_high_time: assert property ($rose(port_c_pin_zero_oe) && port_q[0] && go_hw |-> hi_cnt >= 16'h00C7)
        else $error("bus clock high phase too short");
endmodule // sbbe_engine_props

bind sbbe_engine sbbe_engine_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .port_c_pin_zero_in(port_c_pin_zero_in), .port_c_pin_one_in(port_c_pin_one_in),
    .port_c_pin_zero_out(port_c_pin_zero_out), .port_c_pin_zero_oe(port_c_pin_zero_oe),
    .port_c_pin_one_out(port_c_pin_one_out), .port_c_pin_one_oe(port_c_pin_one_oe),
    .port_c_pin_three_out(port_c_pin_three_out), .port_c_pin_three_oe(port_c_pin_three_oe),
    .vsync_irq_enable(vsync_irq_enable));

// File: tb/sbbe_peer.sv
module sbbe_peer (
    input  wire logic       scl,
    input  wire logic       sda,
    input  wire logic       clr,
    input  wire logic       ack_en,
    input  wire logic       send_en,
    input  wire logic [7:0] send_byte,
    output logic            pull,
    output logic [7:0]      got,
    output logic [3:0]      rises,
    output logic            acked_low
);
    timeunit 1ns;
    timeprecision 1ps;
    logic hi, smp;
    // new frame: count from zero, present the first bit early for plain shift
    always @(posedge clr)
    begin
        rises = 4'h0;
        hi    = 1'b0;
        pull  = send_en & ~send_byte[7];
    end
    // sample on the rise; a pulse counts once it falls, so stop and idle rises are not bits
    always @(posedge scl)
    begin
        smp = sda;
        hi  = 1'b1;
    end
    // commit msb first then the acknowledge; change data while the clock is low
    always @(negedge scl)
    begin
        if (hi && rises < 4'h8)
            got = {got[6:0], smp};
        else if (hi)
            acked_low = ~smp;
        rises = rises + {3'h0, hi};
        hi    = 1'b0;
        pull  = send_en ? rises < 4'h8 && !send_byte[3'h7 - rises[2:0]] : ack_en && rises == 4'h8;
    end
endmodule // sbbe_peer

// File: tb/test_serial_bus_byte_engine.sv
`include "sbbe_defs.vh"
module test_serial_bus_byte_engine;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic        pclk, presetn, psel, penable, pwrite, clr, ack_en, send_en, jam, en_seen;
    logic [11:0] paddr;
    logic [31:0] pwdata, rd_val, e, m;
    logic [7:0]  send_byte;
    wire  [31:0] prdata;
    wire         pready, pslverr, zero_oe, one_oe, three_oe, vsync_en, peer_pull, acked_low;
    wire  [7:0]  got;
    wire  [3:0]  rises;
    integer      seed, n_errors, comparisons, i;
    logic [31:0] exp_q[$], msk_q[$];
    // op: mode[15:12] dir[11] ack[10] jam[9] exp ctrl[7:4] ctrl mask[3:0]
    logic [15:0] ops[7] = '{16'hEC47, 16'hE867, 16'hFE07, 16'hA001, 16'hE001, 16'h1801, 16'h1001};
    wire         scl = ~zero_oe;                       // pull-up on both lines
    wire         sda = ~(one_oe | peer_pull | jam);

    sbbe_engine dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .port_c_pin_zero_in(scl), .port_c_pin_one_in(sda), .port_c_pin_zero_out(), .port_c_pin_zero_oe(zero_oe),
        .port_c_pin_one_out(), .port_c_pin_one_oe(one_oe), .port_c_pin_three_out(),
        .port_c_pin_three_oe(three_oe), .vsync_irq_enable(vsync_en));
    sbbe_peer peer (.scl(scl), .sda(sda), .clr(clr), .ack_en(ack_en), .send_en(send_en), .send_byte(send_byte),
        .pull(peer_pull), .got(got), .rises(rises), .acked_low(acked_low));

    // ----------------------------------------------------------------
    // reporting and bus tasks
    // ----------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] ex, input logic [31:0] g);
        comparisons++;
        if (g !== ex)
        begin
            $display("Error %s expected %h seen %h", name, ex, g);
            n_errors++;
        end
    endtask

    task automatic results;
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic timeout;
        n_errors++;
        results();
    endtask

    // one apb transfer; a read notes its expectation for the monitor
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, ex, mk);
        int k;
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        if (!wr)
        begin
            exp_q.push_back(ex);
            msk_q.push_back(mk);
        end
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 16; k++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        rd_val = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (k == 16)
            timeout();
    endtask

    // poll busy until the byte operation ends
    task automatic wait_idle;
        int k;
        for (k = 0; k < 100; k++)
        begin
            repeat (100) @(posedge pclk);
            apb(1'b0, `SBBE_ADDR_CTRL, 32'h0, 32'h0, 32'h0);
            if (rd_val[`SBBE_BIT_BUSY] === 1'b0)
                break;
        end
        if (k == 100)
            timeout();
    endtask

    // one byte through the engine with the peer answering
    task automatic byte_op(input logic [15:0] op);
        logic [7:0] b;
        b = 8'($random(seed));
        if (op[9])
            b[5:0] = 6'h3F;
        send_byte <= b;
        send_en   <= ~op[11];
        ack_en    <= op[10];
        clr       <= 1'b1;
        en_seen   <= 1'b0;
        apb(1'b1, `SBBE_ADDR_MODE, {28'h0, op[15:12]}, 32'h0, 32'h0);
        clr <= 1'b0;
        apb(1'b1, `SBBE_ADDR_DATA, {24'h0, b}, 32'h0, 32'h0);
        apb(1'b1, `SBBE_ADDR_CTRL, {28'h0, op[11], 3'h1}, 32'h0, 32'h0);
        apb(1'b0, `SBBE_ADDR_DATA, 32'h0, 32'h0, 32'hFF);
        apb(1'b1, `SBBE_ADDR_DATA, {24'h0, ~b}, 32'h0, 32'h0);
        apb(1'b0, `SBBE_ADDR_CTRL, 32'h0, {29'h0, op[11], 2'h1}, {29'h0, op[11], 2'h3});
        if (op[9])
            repeat (600) @(posedge pclk);
        jam <= op[9];
        wait_idle();
        jam <= 1'b0;
        apb(1'b0, `SBBE_ADDR_CTRL, 32'h0, {28'h0, op[7:4]}, {28'h0, op[3:0]});
        apb(1'b0, `SBBE_ADDR_DATA, 32'h0, {24'h0, b}, op[9] ? 32'h0 : 32'hFF);
        if (op[11] && !op[9])
            check("peer byte", {24'h0, b}, {24'h0, got});
        check("bit clocks", op[13] ? 32'h9 : 32'h8, {28'h0, rises});
        if (op[13] && !op[11])
            check("master ack", {31'h0, ~op[14]}, {31'h0, acked_low});
        check("enable pin used", {31'h0, op[13:12] == 2'h3}, {31'h0, en_seen});
    endtask

    // ----------------------------------------------------------------
    // clock, monitor and main sequence
    // ----------------------------------------------------------------
    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    // compare each read at its access edge with the oldest note
    always @(posedge pclk)
    begin
        if (three_oe)
            en_seen <= 1'b1;
        if (psel && penable && pready && !pwrite && exp_q.size() > 0)
        begin
            e = exp_q.pop_front();
            m = msk_q.pop_front();
            if (m != 32'h0)
                check("prdata", e & m, prdata & m);
        end
    end

    initial
    begin
        {presetn, psel, penable, pwrite, clr, ack_en, send_en, jam, en_seen} = 9'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        send_byte = 8'h0;
        seed = 32'h84F8;
        n_errors = 0;
        comparisons = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `SBBE_ADDR_CTRL, 32'h0, 32'h0, 32'hF);
        apb(1'b0, `SBBE_ADDR_MODE, 32'h0, 32'h0, 32'hF);
        apb(1'b0, 12'h0F0, 32'h0, 32'h0, 32'hFFFFFFFF);
        apb(1'b0, `SBBE_ADDR_PORT, 32'h0, 32'hFF, 32'hFF);
        apb(1'b1, `SBBE_ADDR_PORT, 32'hF4, 32'h0, 32'h0);
        @(negedge pclk);
        check("pins pulled", 32'h7, {29'h0, three_oe, one_oe, zero_oe});
        apb(1'b1, `SBBE_ADDR_PORT, 32'hFF, 32'h0, 32'h0);
        @(negedge pclk);
        check("pins free", 32'h0, {29'h0, three_oe, one_oe, zero_oe});
        apb(1'b1, `SBBE_ADDR_CTRL, 32'h4, 32'h0, 32'h0);
        @(negedge pclk);
        check("vsync enable", 32'h1, {31'h0, vsync_en});
        apb(1'b0, `SBBE_ADDR_CTRL, 32'h0, 32'h0, 32'h7);
        $display("test registers done");
        for (i = 0; i < 7; i++)
        begin
            byte_op(ops[i]);
            $display("test byte %0d done", i);
        end
        apb(1'b1, `SBBE_ADDR_MODE, 32'h0, 32'h0, 32'h0);
        apb(1'b1, `SBBE_ADDR_CTRL, 32'h1, 32'h0, 32'h0);
        apb(1'b0, `SBBE_ADDR_CTRL, 32'h0, 32'h0, 32'h1);
        $display("test disabled done");
        results();
    end
endmodule // test_serial_bus_byte_engine
